/* psr_pkg.sv */
// Constants, register map and carrier types of the settings store and relay selector
package psr_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] PSR_CTRL_OFS = 8'h00;
    localparam logic [7:0] PSR_STAT_OFS = 8'h04;
    localparam logic [7:0] PSR_PAR_OFS  = 8'h40;
    localparam int         PSR_NPAR     = 16;
    localparam int         PSR_PW       = 10;

    // CTRL bits
    localparam int PSR_CTRL_ENTER = 0;
    localparam int PSR_CTRL_EXIT  = 1;
    localparam int PSR_CTRL_CLRREJ = 2;

    // Parameter slots
    localparam int PI_INIT_V   = 0;
    localparam int PI_RAMP_UP  = 1;
    localparam int PI_RAMP_DN  = 2;
    localparam int PI_RESTART  = 3;
    localparam int PI_CEIL     = 4;
    localparam int PI_LOAD     = 5;
    localparam int PI_UV       = 6;
    localparam int PI_OV       = 7;
    localparam int PI_PROFILE  = 8;
    localparam int PI_CMDSRC   = 9;
    localparam int PI_STATION  = 10;
    localparam int PI_RELAY    = 11;
    localparam int PI_RATED    = 12;
    localparam int PI_BYPASS   = 13;
    localparam int PI_CUR_DISP = 14;
    localparam int PI_VOL_DISP = 15;

    localparam logic [9:0] PSR_MIN [PSR_NPAR] = '{
        10'h01e, 10'h002, 10'h000, 10'h000, 10'h032, 10'h032, 10'h028, 10'h064,
        10'h000, 10'h000, 10'h000, 10'h000, 10'h00b, 10'h000, 10'h032, 10'h032};
    localparam logic [9:0] PSR_MAX [PSR_NPAR] = '{
        10'h046, 10'h03c, 10'h03c, 10'h3e7, 10'h190, 10'h0c8, 10'h05a, 10'h08c,
        10'h006, 10'h006, 10'h040, 10'h013, 10'h3e6, 10'h028, 10'h096, 10'h096};
    localparam logic [9:0] PSR_DEF [PSR_NPAR] = '{
        10'h028, 10'h010, 10'h000, 10'h000, 10'h190, 10'h064, 10'h050, 10'h078,
        10'h001, 10'h001, 10'h000, 10'h007, 10'h064, 10'h003, 10'h064, 10'h064};

    // ------------------------------------------------------------------
    // Fixed values and timing
    // ------------------------------------------------------------------
    localparam logic [9:0] PSR_FIXED_INIT_V = 10'h028;
    localparam logic [9:0] PSR_FIXED_CEIL   = 10'h190;
    localparam logic [4:0] PSR_INV_BASE     = 5'h0a;
    localparam int         PSR_REF_HZ       = 20_000_000;
    localparam int         PSR_EDIT_IDLE_S  = 120;
    localparam logic [9:0] PSR_PCT          = 10'h064;

    // Start profile codes
    localparam logic [9:0] PSR_PROF_ILIM      = 10'h000;
    localparam logic [9:0] PSR_PROF_VRAMP     = 10'h001;
    localparam logic [9:0] PSR_PROF_KICK_ILIM = 10'h002;
    localparam logic [9:0] PSR_PROF_KICK_V    = 10'h003;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PSR_MS_READY = 3'h0,
        PSR_MS_START = 3'h1,
        PSR_MS_BYP   = 3'h3,
        PSR_MS_STOP  = 3'h2,
        PSR_MS_FAULT = 3'h6
    } psr_mstate_t;

    typedef enum logic [1:0] {
        PSR_ED_VIEW = 2'h0,
        PSR_ED_EDIT = 2'h1
    } psr_edit_t;

    typedef struct packed {
        logic        start_cmd;
        logic        ramp_begin;
        logic        bypass_evt;
        logic        stop_cmd;
        logic        stop_done;
        psr_mstate_t state;
        logic [4:0]  fault_code;
    } psr_motor_t;

    typedef struct packed {
        logic [9:0] init_voltage;
        logic [9:0] ramp_up_time;
        logic [9:0] ramp_down_time;
        logic       coast_stop;
        logic [9:0] current_ceiling;
        logic [9:0] start_profile_select;
        logic [9:0] command_source_select;
        logic [9:0] bus_station_number;
        logic [9:0] motor_rated_current;
        logic [9:0] bypass_delay;
    } psr_settings_t;

endpackage

/* psr_store.sv */
// Settings store with range and edit checks, protection compares and relay selector
`timescale 1ns/100ps
// How it works
// R01: Initial voltage fixed 40% outside voltage-ramp
// R02: Ramp-up 2..60 s, ignored in current-limit
// R03: Ramp-down 0..60 s; zero means coast
// R04: Refuse start until restart interval elapsed
// R05: Current ceiling 50..400%, 400% in voltage-ramp
// R06: Over load ratio times rated flags thermal
// R07: Supply below undervoltage threshold trips
// R08: Supply above overvoltage threshold trips
// R09: Start profile codes 0..6 accepted, 0..3 decoded
// R10: Command source codes 0..6 stored
// R11: Station number 0..64 is bus address
// R12: Rated current 11..998 A is base
// R13: Bypass delay 0..40 s, default 3
// R14: Display factors 50..150% scale readings only
// R15: Leave edit after 2 idle minutes
// R16: No edits during soft start or stop
// R17: Program key at power-up restores defaults
// R18: Selects 0..4 switch on one event
// R19: Selects 5..9 follow a working state
// R20: Relay fault only for listed fault codes
// R21: Running means neither ready nor faulted
// R22: Select above 9 inverts the relay
// R23: Out-of-range entry rejected, value kept
module psr_store
    import psr_pkg::*;
#(
    parameter int CYC_PER_SEC = PSR_REF_HZ
) (
    // Clock, reset, enable
    input  wire logic          I_REF_CLK,
    input  wire logic          I_SYS_RST,
    input  wire logic          I_CLK_EN,
    // AXI4-Lite slave
    input  wire logic [7:0]    I_AXI_AWADDR,
    input  wire logic          I_AXI_AWVALID,
    output logic               O_AXI_AWREADY,
    input  wire logic [31:0]   I_AXI_WDATA,
    input  wire logic [3:0]    I_AXI_WSTRB,
    input  wire logic          I_AXI_WVALID,
    output logic               O_AXI_WREADY,
    output logic [1:0]         O_AXI_BRESP,
    output logic               O_AXI_BVALID,
    input  wire logic          I_AXI_BREADY,
    input  wire logic [7:0]    I_AXI_ARADDR,
    input  wire logic          I_AXI_ARVALID,
    output logic               O_AXI_ARREADY,
    output logic [31:0]        O_AXI_RDATA,
    output logic [1:0]         O_AXI_RRESP,
    output logic               O_AXI_RVALID,
    input  wire logic          I_AXI_RREADY,
    // Keypad pins
    input  wire logic          I_KEY_PRESS,
    input  wire logic          I_PROGRAM_KEY,
    // Motor controller side
    input  wire psr_motor_t    I_MOTOR,
    input  wire logic          I_START_REQ,
    input  wire logic [11:0]   I_MOTOR_AMPS,
    input  wire logic [9:0]    I_SUPPLY_PCT,
    input  wire logic [15:0]   I_RAW_CURRENT,
    input  wire logic [15:0]   I_RAW_VOLTAGE,
    // Results
    output psr_settings_t      O_SETTINGS,
    output logic               O_START_GRANT,
    output logic               O_START_PERMIT,
    output logic               O_THERMAL_OVER,
    output logic               O_UNDERVOLT_TRIP,
    output logic               O_OVERVOLT_TRIP,
    output logic [15:0]        O_DISP_CURRENT,
    output logic [15:0]        O_DISP_VOLTAGE,
    output logic               O_RELAY
);
    localparam int TW = $clog2(CYC_PER_SEC + 1);
    if (CYC_PER_SEC < 2) begin : g_chk
        $error("CYC_PER_SEC must be at least 2");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and second tick
    // ------------------------------------------------------------------
    logic [2:0]    key_r;
    logic [1:0]    prg_r;
    logic [TW-1:0] tick_cnt_r;
    logic          tick;
    logic          key_edge;
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            key_r <= 3'h0;
            prg_r <= 2'h0;
        end else if (I_CLK_EN) begin
            key_r <= {key_r[1:0], I_KEY_PRESS};
            prg_r <= {prg_r[0], I_PROGRAM_KEY};
        end
    end
    assign key_edge = key_r[1] & ~key_r[2];
    assign tick     = (tick_cnt_r == TW'(CYC_PER_SEC - 1));
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            tick_cnt_r <= '0;
        end else if (I_CLK_EN) begin
            tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------------
    logic        aw_hold_r, w_hold_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_fire;
    logic        wr_ctrl, wr_par, wr_map;
    logic [3:0]  wr_idx;
    assign wr_fire = aw_hold_r & w_hold_r & ~O_AXI_BVALID;
    assign wr_idx  = awaddr_r[5:2];
    assign wr_ctrl = (awaddr_r[7:2] == PSR_CTRL_OFS[7:2]);
    assign wr_par  = (awaddr_r[7:6] == PSR_PAR_OFS[7:6]);
    assign wr_map  = wr_ctrl | wr_par | (awaddr_r[7:2] == PSR_STAT_OFS[7:2]);
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_AXI_AWREADY <= 1'b1;
            O_AXI_WREADY  <= 1'b1;
            O_AXI_BVALID  <= 1'b0;
            O_AXI_BRESP   <= 2'h0;
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
        end else if (I_CLK_EN) begin
            if (I_AXI_AWVALID && O_AXI_AWREADY) begin
                aw_hold_r     <= 1'b1;
                awaddr_r      <= I_AXI_AWADDR;
                O_AXI_AWREADY <= 1'b0;
            end
            if (I_AXI_WVALID && O_AXI_WREADY) begin
                w_hold_r     <= 1'b1;
                wdata_r      <= I_AXI_WDATA;
                wstrb_r      <= I_AXI_WSTRB;
                O_AXI_WREADY <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                O_AXI_BVALID <= 1'b1;
                O_AXI_BRESP  <= wr_map ? 2'h0 : 2'h2;
            end
            if (O_AXI_BVALID && I_AXI_BREADY) begin
                O_AXI_BVALID  <= 1'b0;
                O_AXI_AWREADY <= 1'b1;
                O_AXI_WREADY  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Edit session
    // ------------------------------------------------------------------
    psr_edit_t  edit_st_r;
    logic [6:0] idle_s_r;
    logic       busy;
    logic       par_ok;
    logic       rej_r;
    logic [9:0] wval;
    logic [9:0] par_r [PSR_NPAR];
    assign busy = (I_MOTOR.state == PSR_MS_START) || (I_MOTOR.state == PSR_MS_STOP);
    assign wval = wdata_r[9:0];
    assign par_ok = wr_fire && wr_par && (edit_st_r == PSR_ED_EDIT) && !busy // R16
                    && (&wstrb_r[1:0]) && (wdata_r[31:10] == 22'h0)
                    && (wval >= PSR_MIN[wr_idx]) && (wval <= PSR_MAX[wr_idx]); // R23
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            edit_st_r <= PSR_ED_VIEW;
            idle_s_r  <= 7'h00;
        end else if (I_CLK_EN) begin
            case (edit_st_r)
                PSR_ED_VIEW: begin
                    idle_s_r <= 7'h00;
                    if (wr_fire && wr_ctrl && wstrb_r[0] && wdata_r[PSR_CTRL_ENTER] && !busy) begin
                        edit_st_r <= PSR_ED_EDIT; // R16
                    end
                end
                PSR_ED_EDIT: begin
                    if (key_edge || par_ok) begin
                        idle_s_r <= 7'h00;
                    end else if (tick) begin
                        idle_s_r <= idle_s_r + 7'h01;
                    end
                    if (wr_fire && wr_ctrl && wstrb_r[0] && wdata_r[PSR_CTRL_EXIT]) begin
                        edit_st_r <= PSR_ED_VIEW;
                    end else if (idle_s_r >= 7'(PSR_EDIT_IDLE_S) && !key_edge) begin
                        edit_st_r <= PSR_ED_VIEW; // R15
                    end
                end
                default: begin
                    edit_st_r <= PSR_ED_VIEW;
                end
            endcase
        end
    end

    // Sticky reject flag: a new reject wins over a clear
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            rej_r <= 1'b0;
        end else if (I_CLK_EN) begin
            if (wr_fire && wr_par && !par_ok) begin
                rej_r <= 1'b1; // R23
            end else if (wr_fire && wr_ctrl && wstrb_r[0] && wdata_r[PSR_CTRL_CLRREJ]) begin
                rej_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Parameter store and power-up restore
    // ------------------------------------------------------------------
    logic [2:0] boot_cnt_r;
    logic       restore;
    assign restore = (boot_cnt_r == 3'h3) && prg_r[1];
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            boot_cnt_r <= 3'h0;
        end else if (I_CLK_EN && boot_cnt_r != 3'h4) begin
            boot_cnt_r <= boot_cnt_r + 3'h1;
        end
    end
    for (genvar g = 0; g < PSR_NPAR; g++) begin : g_par
        always_ff @(posedge I_REF_CLK) begin
            if (I_SYS_RST) begin
                par_r[g] <= PSR_DEF[g];
            end else if (I_CLK_EN) begin
                if (restore) begin
                    par_r[g] <= PSR_DEF[g]; // R17
                end else if (par_ok && (wr_idx == 4'(g))) begin
                    par_r[g] <= wval; // R23
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Effective settings
    // ------------------------------------------------------------------
    logic [9:0] prof;
    logic       ilim_mode, vramp_mode;
    assign prof       = par_r[PI_PROFILE];
    assign ilim_mode  = (prof == PSR_PROF_ILIM) || (prof == PSR_PROF_KICK_ILIM); // R09
    assign vramp_mode = (prof == PSR_PROF_VRAMP) || (prof == PSR_PROF_KICK_V); // R09
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_SETTINGS <= '0;
        end else if (I_CLK_EN) begin
            O_SETTINGS.init_voltage <= vramp_mode ? par_r[PI_INIT_V] : PSR_FIXED_INIT_V; // R01
            O_SETTINGS.ramp_up_time <= ilim_mode ? 10'h000 : par_r[PI_RAMP_UP]; // R02
            O_SETTINGS.ramp_down_time <= par_r[PI_RAMP_DN]; // R03
            O_SETTINGS.coast_stop <= (par_r[PI_RAMP_DN] == 10'h000); // R03
            O_SETTINGS.current_ceiling <= vramp_mode ? PSR_FIXED_CEIL : par_r[PI_CEIL]; // R05
            O_SETTINGS.start_profile_select <= prof; // R09
            O_SETTINGS.command_source_select <= par_r[PI_CMDSRC]; // R10
            O_SETTINGS.bus_station_number <= par_r[PI_STATION]; // R11
            O_SETTINGS.motor_rated_current <= par_r[PI_RATED]; // R12
            O_SETTINGS.bypass_delay <= par_r[PI_BYPASS]; // R13
        end
    end

    // ------------------------------------------------------------------
    // Protection compares and display scaling
    // ------------------------------------------------------------------
    logic [19:0] load_lim;
    logic [25:0] disp_i, disp_v;
    assign load_lim = (par_r[PI_RATED] * par_r[PI_LOAD]) / 20'(PSR_PCT);
    assign disp_i   = (I_RAW_CURRENT * par_r[PI_CUR_DISP]) / 26'(PSR_PCT);
    assign disp_v   = (I_RAW_VOLTAGE * par_r[PI_VOL_DISP]) / 26'(PSR_PCT);
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_THERMAL_OVER   <= 1'b0;
            O_UNDERVOLT_TRIP <= 1'b0;
            O_OVERVOLT_TRIP  <= 1'b0;
            O_DISP_CURRENT   <= 16'h0000;
            O_DISP_VOLTAGE   <= 16'h0000;
        end else if (I_CLK_EN) begin
            O_THERMAL_OVER   <= {8'h00, I_MOTOR_AMPS} > load_lim; // R06 R12
            O_UNDERVOLT_TRIP <= I_SUPPLY_PCT < par_r[PI_UV]; // R07
            O_OVERVOLT_TRIP  <= I_SUPPLY_PCT > par_r[PI_OV]; // R08
            O_DISP_CURRENT   <= disp_i[15:0]; // R14
            O_DISP_VOLTAGE   <= disp_v[15:0]; // R14
        end
    end

    // ------------------------------------------------------------------
    // Restart interval
    // ------------------------------------------------------------------
    logic [9:0] gap_s_r;
    logic       grant;
    assign grant = I_START_REQ && (gap_s_r == 10'h000) && (I_MOTOR.state == PSR_MS_READY);
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            gap_s_r        <= 10'h000;
            O_START_GRANT  <= 1'b0;
            O_START_PERMIT <= 1'b0;
        end else if (I_CLK_EN) begin
            O_START_GRANT  <= grant; // R04
            O_START_PERMIT <= (gap_s_r == 10'h000);
            if (grant) begin
                gap_s_r <= par_r[PI_RESTART]; // R04
            end else if (tick && gap_s_r != 10'h000) begin
                gap_s_r <= gap_s_r - 10'h001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Programmable relay
    // ------------------------------------------------------------------
    logic [4:0] rsel, rbase, evts;
    logic       evt_r;
    logic       evt_set, evt_clr;
    logic       flt_code, st_val;
    assign rsel    = par_r[PI_RELAY][4:0];
    assign rbase   = (rsel >= PSR_INV_BASE) ? rsel - PSR_INV_BASE : rsel;
    assign evts    = {I_MOTOR.stop_done, I_MOTOR.stop_cmd, I_MOTOR.bypass_evt,
                      I_MOTOR.ramp_begin, I_MOTOR.start_cmd};
    // Timing selects latch on their event; 0..2 drop at stop, 3..4 at start
    assign evt_set = (rbase < 5'h05) && evts[rbase[2:0]]; // R18
    assign evt_clr = (rbase < 5'h03) ? I_MOTOR.stop_done
                   : (rbase < 5'h05) ? I_MOTOR.start_cmd : 1'b1;
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            evt_r <= 1'b0;
        end else if (I_CLK_EN) begin
            if (evt_set) begin
                evt_r <= 1'b1;
            end else if (evt_clr) begin
                evt_r <= 1'b0;
            end
        end
    end

    always_comb begin
        case (I_MOTOR.fault_code)
            5'h05, 5'h06, 5'h07, 5'h08, 5'h0c, 5'h0f: flt_code = 1'b1; // R20
            default: flt_code = 1'b0;
        endcase
        case (rbase)
            5'h05: st_val = (I_MOTOR.state == PSR_MS_FAULT) && flt_code; // R19 R20
            5'h06: st_val = (I_MOTOR.state != PSR_MS_READY)
                            && (I_MOTOR.state != PSR_MS_FAULT); // R21
            5'h07: st_val = (I_MOTOR.state == PSR_MS_READY); // R19
            5'h08: st_val = (I_MOTOR.state == PSR_MS_START); // R19
            5'h09: st_val = (I_MOTOR.state == PSR_MS_BYP); // R19
            default: st_val = evt_r; // R18
        endcase
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_RELAY <= 1'b0;
        end else if (I_CLK_EN) begin
            O_RELAY <= st_val ^ (rsel >= PSR_INV_BASE); // R22
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (I_AXI_ARADDR[7:6] == PSR_PAR_OFS[7:6]) begin
            rd_mux = {22'h0, par_r[I_AXI_ARADDR[5:2]]};
        end else if (I_AXI_ARADDR[7:2] == PSR_STAT_OFS[7:2]) begin
            rd_mux = {26'h0, O_RELAY, O_START_PERMIT, rej_r, busy,
                      1'b0, (edit_st_r == PSR_ED_EDIT)};
        end else if (I_AXI_ARADDR[7:2] != PSR_CTRL_OFS[7:2]) begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_AXI_ARREADY <= 1'b1;
            O_AXI_RVALID  <= 1'b0;
            O_AXI_RDATA   <= 32'h0000_0000;
            O_AXI_RRESP   <= 2'h0;
        end else if (I_CLK_EN) begin
            if (I_AXI_ARVALID && O_AXI_ARREADY) begin
                O_AXI_ARREADY <= 1'b0;
                O_AXI_RVALID  <= 1'b1;
                O_AXI_RDATA   <= rd_mux;
                O_AXI_RRESP   <= rd_ok ? 2'h0 : 2'h2;
            end else if (O_AXI_RVALID && I_AXI_RREADY) begin
                O_AXI_RVALID  <= 1'b0;
                O_AXI_ARREADY <= 1'b1;
            end
        end
    end

endmodule

/* psr_motor_model.sv */
// Motor core stand-in: working state in, status and event pulses out
`timescale 1ns/100ps
module psr_motor_model
    import psr_pkg::*;
(
    // Clock and commanded state
    input  wire logic        i_clk,
    input  wire psr_mstate_t i_state,
    input  wire logic [4:0]  i_code,
    // Status towards the store
    output psr_motor_t       o_motor
);
    psr_mstate_t prev_r = PSR_MS_READY;
    always_ff @(posedge i_clk) prev_r <= i_state;
    // Each event lasts one cycle, on the first cycle of the new state
    always_comb begin
        o_motor = {5'h00, i_state, i_code};
        o_motor.start_cmd = i_state == PSR_MS_START && prev_r == PSR_MS_READY;
        o_motor.ramp_begin = o_motor.start_cmd;
        o_motor.bypass_evt = i_state == PSR_MS_BYP && prev_r != PSR_MS_BYP;
        o_motor.stop_cmd = i_state == PSR_MS_STOP && prev_r != PSR_MS_STOP;
        o_motor.stop_done = i_state == PSR_MS_READY && prev_r == PSR_MS_STOP;
    end
endmodule

/* psr_store_props.sv */
// Concurrent checks on the settings store outputs
`timescale 1ns/100ps
module psr_store_props
    import psr_pkg::*;
(
    // Clock and reset
    input wire logic          I_REF_CLK,
    input wire logic          I_SYS_RST,
    // Start request and motor status
    input wire logic          I_START_REQ,
    input wire psr_motor_t    I_MOTOR,
    // Observed outputs
    input wire psr_settings_t O_SETTINGS,
    input wire logic          O_START_GRANT,
    input wire logic          O_START_PERMIT
);
    logic [1:0] up_r;
    wire [9:0] pf = O_SETTINGS.start_profile_select;
    wire vr = pf == 10'h001 || pf == 10'h003;
    wire ok = up_r == 2'h3;
    // Settings output is only meaningful a few edges after reset
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            up_r <= 2'h0;
        end else if (!ok) begin
            up_r <= up_r + 2'h1;
        end
    end
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);
    sequence asked_s;
        $past(I_START_REQ) && O_START_PERMIT && $past(I_MOTOR.state) == PSR_MS_READY;
    endsequence
    init_fix_a: assert property (ok && !vr |-> O_SETTINGS.init_voltage == 10'h028)
        else $error("initial voltage not fixed");
    ramp_off_a: assert property (ok && (pf == 10'h000 || pf == 10'h002)
        |-> O_SETTINGS.ramp_up_time == 10'h000) else $error("ramp time used");
    coast_a: assert property (ok |-> O_SETTINGS.coast_stop ==
        (O_SETTINGS.ramp_down_time == 10'h000)) else $error("coast flag wrong");
    ceil_fix_a: assert property (ok && vr |-> O_SETTINGS.current_ceiling == 10'h190)
        else $error("ceiling not fixed");
    profile_range_a: assert property (ok |-> pf <= 10'h006) else $error("bad profile");
    station_range_a: assert property (ok |-> O_SETTINGS.bus_station_number <= 10'h040)
        else $error("bad station");
    rated_range_a: assert property (ok |-> O_SETTINGS.motor_rated_current inside
        {[10'h00b:10'h3e6]}) else $error("bad rated current");
    grant_cause_a: assert property (ok && O_START_GRANT |-> asked_s)
        else $error("grant without cause");
endmodule
bind psr_store psr_store_props i_props (.*);

/* tb_psr_store.sv */
// Self-checking bench of the settings store and relay selector
`timescale 1ns/100ps
module tb_psr_store;
    import psr_pkg::*;
    logic I_REF_CLK = 1'b0, I_SYS_RST = 1'b1, I_CLK_EN = 1'b1, I_KEY_PRESS = 1'b0;
    logic I_PROGRAM_KEY = 1'b0, I_START_REQ = 1'b0, I_AXI_AWVALID = 1'b0, I_AXI_WVALID = 1'b0;
    logic I_AXI_BREADY = 1'b0, I_AXI_ARVALID = 1'b0, I_AXI_RREADY = 1'b0;
    logic [7:0] I_AXI_AWADDR = 8'h00, I_AXI_ARADDR = 8'h00;
    logic [31:0] I_AXI_WDATA = 32'h0, O_AXI_RDATA, rd;
    logic [3:0] I_AXI_WSTRB = 4'hf;
    logic [11:0] I_MOTOR_AMPS = 12'h000;
    logic [9:0] I_SUPPLY_PCT = 10'h064;
    logic [15:0] I_RAW_CURRENT = 16'h1234, I_RAW_VOLTAGE = 16'h0000;
    logic [15:0] O_DISP_CURRENT, O_DISP_VOLTAGE;
    logic O_AXI_AWREADY, O_AXI_WREADY, O_AXI_BVALID, O_AXI_ARREADY, O_AXI_RVALID, O_RELAY;
    logic O_START_GRANT, O_START_PERMIT, O_THERMAL_OVER, O_UNDERVOLT_TRIP, O_OVERVOLT_TRIP;
    logic [1:0] O_AXI_BRESP, O_AXI_RRESP, rs;
    logic [2:0] st = 3'h0;
    logic [4:0] code = 5'h00;
    psr_settings_t O_SETTINGS;
    psr_motor_t I_MOTOR;
    int miscompares = 0, compares = 0;
    psr_motor_model i_motor (.i_clk(I_REF_CLK), .i_state(psr_mstate_t'(st)), .i_code(code),
        .o_motor(I_MOTOR));
    psr_store #(.CYC_PER_SEC(10)) i_dut (.*);
    initial forever #25 I_REF_CLK = ~I_REF_CLK;
    function automatic logic [7:0] p(input int i);
        return PSR_PAR_OFS + 8'(4 * i);
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [9:0] d);
        @(posedge I_REF_CLK);
        I_AXI_AWADDR <= a; I_AXI_WDATA <= {22'h0, d};
        I_AXI_AWVALID <= 1'b1; I_AXI_WVALID <= 1'b1; I_AXI_BREADY <= 1'b1;
        fork
            begin do @(posedge I_REF_CLK); while (!O_AXI_AWREADY); I_AXI_AWVALID <= 1'b0; end
            begin do @(posedge I_REF_CLK); while (!O_AXI_WREADY); I_AXI_WVALID <= 1'b0; end
        join
        do @(posedge I_REF_CLK); while (!O_AXI_BVALID);
        I_AXI_BREADY <= 1'b0;
    endtask
    task automatic rdp(input logic [7:0] a);
        @(posedge I_REF_CLK);
        I_AXI_ARADDR <= a; I_AXI_ARVALID <= 1'b1; I_AXI_RREADY <= 1'b1;
        do @(posedge I_REF_CLK); while (!O_AXI_ARREADY);
        I_AXI_ARVALID <= 1'b0;
        do @(posedge I_REF_CLK); while (!O_AXI_RVALID);
        rd = O_AXI_RDATA; rs = O_AXI_RRESP; I_AXI_RREADY <= 1'b0;
    endtask
    task automatic put(input logic [2:0] s, input logic [4:0] c);
        @(posedge I_REF_CLK);
        st <= s; code <= c;
    endtask
    task automatic t_defaults();
        int ix[7] = '{1, 2, 4, 6, 7, 10, 13};
        logic [9:0] dv[7] = '{10'h010, 10'h000, 10'h190, 10'h050, 10'h078, 10'h000, 10'h003};
        I_SUPPLY_PCT <= 10'h02d; I_MOTOR_AMPS <= 12'h065;
        foreach (ix[k]) begin
            rdp(p(ix[k]));
            chk("default", rd, {22'h0, dv[k]});
        end
        rdp(8'h10);
        chk("unmapped", {30'h0, rs}, 32'h2);
        chk("display", {16'h0, O_DISP_CURRENT}, 32'h1234);
        chk("trips", {29'h0, O_THERMAL_OVER, O_UNDERVOLT_TRIP, O_OVERVOLT_TRIP}, 32'h6);
    endtask
    task automatic t_edit();
        wr(PSR_CTRL_OFS, 10'h001);
        wr(p(1), 10'h03d); rdp(p(1));
        chk("range", rd, 32'h10);
        wr(p(1), 10'h002); rdp(p(1));
        chk("low", rd, 32'h2);
        put(3'h1, 5'h00);
        wr(p(1), 10'h009); rdp(p(1));
        chk("busy", rd, 32'h2);
        put(3'h0, 5'h00);
        wr(p(0), 10'h032); rdp(p(0));
        chk("ramp init", {22'h0, O_SETTINGS.init_voltage}, 32'h32);
        wr(p(8), 10'h000); rdp(p(8));
        chk("fixed", {22'h0, O_SETTINGS.init_voltage}, 32'h28);
    endtask
    task automatic t_relay();
        int sl[10] = '{7, 17, 5, 5, 5, 6, 6, 8, 9, 0};
        int ms[10] = '{0, 0, 6, 6, 6, 3, 0, 1, 3, 1};
        int fc[10] = '{0, 0, 5, 15, 9, 0, 0, 0, 0, 0};
        logic [9:0] ex = 10'h3ad;
        foreach (sl[k]) begin
            put(3'h0, 5'h00);
            wr(p(11), 10'(sl[k]));
            put(3'(ms[k]), 5'(fc[k]));
            repeat (3) @(posedge I_REF_CLK);
            chk("relay", {31'h0, O_RELAY}, {31'h0, ex[k]});
        end
        put(3'h0, 5'h00);
    endtask
    task automatic t_start();
        int n = 0;
        wr(p(3), 10'h002);
        @(posedge I_REF_CLK) I_START_REQ <= 1'b1;
        @(posedge I_REF_CLK) I_START_REQ <= 1'b0;
        @(posedge I_REF_CLK);
        chk("grant", {31'h0, O_START_GRANT}, 32'h1);
        I_START_REQ <= 1'b1;
        repeat (5) begin
            @(posedge I_REF_CLK);
            n += int'(O_START_GRANT);
        end
        I_START_REQ <= 1'b0;
        chk("early", 32'(n), 32'h0);
        chk("held", {31'h0, O_START_PERMIT}, 32'h0);
        repeat (30) @(posedge I_REF_CLK);
        chk("permit", {31'h0, O_START_PERMIT}, 32'h1);
    endtask
    task automatic summarize();
        if (miscompares == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge I_REF_CLK);
        I_SYS_RST <= 1'b0;
        t_defaults(); t_edit(); t_relay(); t_start();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge I_REF_CLK);
        miscompares++;
        summarize();
    end
endmodule
